/* include/bcs_pkg.sv */
// Purpose: shared constants for the bypass contactor sequencer
// Assumes: 50 MHz pclk, APB with 32-bit data, one register per aligned word
// Notes: times are held in units of 0.1 s, frequencies in units of 0.01 Hz

// ==========================================================================
// package
package bcs_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 100_000_000; // one time unit = 0.1 s
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 23;
  localparam int TIME_W = 10;
  localparam int FREQ_W = 16;
  localparam int NTERM = 4;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INTERLOCK = 8'h04;
  localparam logic [7:0] OFS_START_WAIT = 8'h08;
  localparam logic [7:0] OFS_CUSHION = 8'h0C;
  localparam logic [7:0] OFS_AUTO_FREQ = 8'h10;
  localparam logic [7:0] OFS_IN_FUNC = 8'h14;
  localparam logic [7:0] OFS_OUT_FUNC = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // control field positions
  localparam int CTRL_SEQ_EN = 0;
  localparam int CTRL_AT_FAULT = 1;
  localparam int CTRL_RST_ACCEPT = 2;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h5;
  localparam logic [TIME_W-1:0] INTERLOCK_RST = 10'h00A; // 1 s
  localparam logic [TIME_W-1:0] START_WAIT_RST = 10'h005; // 0.5 s
  localparam logic [TIME_W-1:0] CUSHION_RST = 10'h00A; // 1 s
  localparam logic [FREQ_W-1:0] AUTO_FREQ_OFF = 16'h270F; // 9999 disables
  localparam logic [31:0] IN_FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_FUNC_RST = 32'h0013_1211; // 17, 18, 19, none

  // terminal function codes
  localparam logic [7:0] FC_THERMAL = 8'h07;
  localparam logic [7:0] FC_IN_CONT = 8'h11;
  localparam logic [7:0] FC_BYP_CONT = 8'h12;
  localparam logic [7:0] FC_OUT_CONT = 8'h13;

  // sequencer modes, one-hot
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_DRIVE = 5'b00010,
    ST_BYPASS = 5'b00100,
    ST_FAULT = 5'b01000,
    ST_PASS = 5'b10000
  } bcs_state_e;

endpackage : bcs_pkg

/* rtl/bcs_timer.sv */
// Purpose: reloadable down counter of 0.1 s ticks
// Assumes: tick is a one-cycle pulse from the prescaler
// Notes: done stays high once the loaded time has run out

`timescale 1ns/1ps

// ==========================================================================
// timer
module bcs_timer
  import bcs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic tick,
  input wire logic [bcs_pkg::TIME_W-1:0] len,
  // status
  output logic done
);

  typedef struct packed {
    logic [TIME_W-1:0] cnt;
    logic done;
    logic live;
  } bcs_tmr_s;

  bcs_tmr_s r;
  bcs_tmr_s next_r;

  // reload while held or on the first cycle after reset, count down on ticks
  // without the reset load a zero count would never report done
  always_comb
  begin
    next_r = r;
    next_r.live = 1'b1;
    if (restart || !r.live)
    begin
      next_r.cnt = len;
      next_r.done = (len == '0);
    end
    else if (tick && r.cnt != '0)
    begin
      next_r.cnt = r.cnt - 1'b1;
      next_r.done = (r.cnt == 10'h001);
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign done = r.done;

endmodule : bcs_timer

/* rtl/bcs_sequencer.sv */
// Purpose: contactor sequencing for switching a motor between drive and mains
// Assumes: all inputs synchronous to pclk; registers reached over APB
// Notes: contactor outputs and terminal outputs come straight from flops
//
// Operation
// R1 - input contactor on in bypass and drive; off at fault until reset
// R2 - bypass contactor on in bypass, off in drive, fault per setting
// R3 - output contactor off in bypass, on in drive, off at fault
// R4 - enable low: input on, bypass off, output holds its state
// R5 - select acts only when enabled: high drive, low bypass
// R6 - run command accepted only with enable and select high
// R7 - thermal input on code 7 terminal; abnormal releases all contactors
// R8 - init input releases bypass; fault reset accepted per acceptance setting
// R9 - output terminals carry contactor controls by codes 17, 18, 19
// R10 - switchover frequency 9999 disables automatic switchover
// R11 - start waiting time should exceed output contactor closing delay
// R12 - restart cushion time is set for bypass to drive switching; the cushion register is stored and read back but not used
// R13 - sequencing is used with the drive in external operation mode
// R14 - from both contactors off, wait interlock time before closing either
// R15 - drive start after coasting from bypass waits start waiting time
// R16 - auto switchover to bypass once output frequency reaches setting
// R17 - bypass and output contactors are never on together

`timescale 1ns/1ps

// ==========================================================================
// sequencer top
module bcs_sequencer #(
  parameter int TICK_CYCLES = bcs_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operator and drive inputs
  input wire logic bypass_enable_input,
  input wire logic drive_select_input,
  input wire logic forward_run_command,
  input wire logic reverse_run_command,
  input wire logic status_init_input,
  input wire logic drive_fault,
  input wire logic external_mode,
  input wire logic [bcs_pkg::FREQ_W-1:0] output_freq,
  input wire logic [bcs_pkg::NTERM-1:0] in_term,
  // contactor controls and terminals
  output logic input_contactor_ctrl,
  output logic bypass_contactor_ctrl,
  output logic output_contactor_ctrl,
  output logic [bcs_pkg::NTERM-1:0] out_term,
  // drive start
  output logic drive_run_fwd,
  output logic drive_run_rev
);
  import bcs_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ctrl;
    logic [TIME_W-1:0] interlock;
    logic [TIME_W-1:0] start_wait;
    logic [TIME_W-1:0] cushion;
    logic [FREQ_W-1:0] auto_freq;
    logic [NTERM-1:0][7:0] in_func;
    logic [NTERM-1:0][7:0] out_func;
    logic [PRE_W-1:0] pre;
    logic tick;
    logic mc_in;
    logic mc_byp;
    logic mc_out;
    logic [NTERM-1:0] term;
    logic fault;
    logic coasted;
    logic auto_byp;
    logic run_fwd;
    logic run_rev;
    bcs_state_e st;
  } bcs_regs_s;

  bcs_regs_s r;
  bcs_regs_s next_r;
  logic il_done;
  logic sw_done;
  logic seq_act;
  logic thermal_bad;
  logic fault_now;
  logic run_cmd;
  logic want_in;
  logic want_byp;
  logic want_out;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_val;
  logic rd_hit;

  // ========================================================================
  // timers
  // interlock timer reloads while either motor contactor is closed
  bcs_timer u_interlock (
    .pclk(pclk),
    .presetn(presetn),
    .restart(r.mc_byp | r.mc_out),
    .tick(r.tick),
    .len(r.interlock),
    .done(il_done)
  );

  // start wait timer reloads while the output contactor is open
  bcs_timer u_start_wait (
    .pclk(pclk),
    .presetn(presetn),
    .restart(~r.mc_out),
    .tick(r.tick),
    .len(r.start_wait),
    .done(sw_done)
  );

  // ========================================================================
  // input decode
  // thermal input is high when normal and low when abnormal on any terminal coded for it
  always_comb
  begin
    thermal_bad = 1'b0;
    for (int i = 0; i < NTERM; i++)
    begin
      if (r.in_func[i] == FC_THERMAL && !in_term[i])
        thermal_bad = 1'b1; // R7
    end
  end

  assign seq_act = r.ctrl[CTRL_SEQ_EN] & external_mode; // R13
  assign fault_now = drive_fault | r.fault;
  assign run_cmd = forward_run_command ^ reverse_run_command;

  // ========================================================================
  // apb decode and read mux
  assign wr_en = psel & penable & r.pready & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_val = {29'h0000_0000, r.ctrl};
      OFS_INTERLOCK: rd_val = {22'h00_0000, r.interlock};
      OFS_START_WAIT: rd_val = {22'h00_0000, r.start_wait};
      OFS_CUSHION: rd_val = {22'h00_0000, r.cushion};
      OFS_AUTO_FREQ: rd_val = {16'h0000, r.auto_freq};
      OFS_IN_FUNC: rd_val = r.in_func;
      OFS_OUT_FUNC: rd_val = r.out_func;
      OFS_STATUS: rd_val = {16'h0000, 3'h0, r.st, r.auto_byp, r.coasted,
                            r.fault, thermal_bad, r.run_fwd, r.mc_out,
                            r.mc_byp, r.mc_in};
      default: rd_hit = 1'b0;
    endcase
  end

  // ========================================================================
  // contactor targets
  always_comb
  begin
    want_in = 1'b1;
    want_byp = 1'b0;
    want_out = 1'b1;
    if (!seq_act)
    begin
      want_in = 1'b1;
      want_byp = 1'b0;
      want_out = 1'b1;
    end
    else if (thermal_bad)
    begin
      want_in = 1'b0; // R7
      want_byp = 1'b0; // R2
      want_out = 1'b0;
    end
    else if (fault_now)
    begin
      want_in = 1'b0; // R1
      want_byp = r.ctrl[CTRL_AT_FAULT]; // R2
      want_out = 1'b0; // R3
    end
    else if (!bypass_enable_input)
    begin
      want_in = 1'b1; // R4
      want_byp = 1'b0;
      want_out = r.mc_out;
    end
    else if (drive_select_input && !r.auto_byp)
    begin
      want_in = 1'b1; // R5
      want_byp = 1'b0;
      want_out = 1'b1; // R3
    end
    else
    begin
      want_in = 1'b1; // R5
      want_byp = 1'b1; // R2
      want_out = 1'b0;
    end
    // init releases bypass only, input and output hold
    if (seq_act && status_init_input && !thermal_bad)
    begin
      want_in = r.mc_in; // R8
      want_byp = 1'b0;
      want_out = r.mc_out;
    end
  end

  // ========================================================================
  // next state
  always_comb
  begin
    next_r = r;
    // apb answer in the access cycle, no wait states
    next_r.pready = psel & ~penable;
    next_r.pslverr = psel & ~penable & ~rd_hit;
    if (rd_en)
      next_r.prdata = rd_hit ? rd_val : 32'h0000_0000;
    if (wr_en && rd_hit)
    begin
      case (paddr)
        OFS_CTRL: next_r.ctrl = pwdata[2:0];
        OFS_INTERLOCK: next_r.interlock = pwdata[TIME_W-1:0];
        OFS_START_WAIT: next_r.start_wait = pwdata[TIME_W-1:0];
        OFS_CUSHION: next_r.cushion = pwdata[TIME_W-1:0];
        OFS_AUTO_FREQ: next_r.auto_freq = pwdata[FREQ_W-1:0];
        OFS_IN_FUNC: next_r.in_func = pwdata;
        OFS_OUT_FUNC: next_r.out_func = pwdata;
        default: next_r.prdata = r.prdata;
      endcase
    end
    // 0.1 s prescaler
    next_r.tick = (r.pre == PRE_W'(TICK_CYCLES - 1));
    next_r.pre = next_r.tick ? '0 : r.pre + 1'b1;
    // fault latch, a new fault wins over an accepted init
    if (drive_fault)
      next_r.fault = 1'b1; // R1
    else if (status_init_input && r.ctrl[CTRL_RST_ACCEPT])
      next_r.fault = 1'b0; // R8
    // contactors: input follows its target; bypass and output open at once, close only from both open after interlock
    next_r.mc_in = want_in; // R1
    next_r.mc_byp = want_byp & (r.mc_byp | (~r.mc_out & il_done & ~want_out)); // R14
    next_r.mc_out = want_out & (r.mc_out | (~r.mc_byp & il_done & ~want_byp)); // R17
    // automatic switchover, 9999 leaves only the select input in charge
    if (!run_cmd || !drive_select_input || !bypass_enable_input || fault_now)
      next_r.auto_byp = 1'b0;
    else if (r.auto_freq != AUTO_FREQ_OFF && r.mc_out
             && output_freq >= r.auto_freq)
      next_r.auto_byp = 1'b1; // R16 R10
    // motor coasts whenever the bypass contactor opens
    if (r.mc_byp && !next_r.mc_byp)
      next_r.coasted = 1'b1; // R15
    else if (r.run_fwd || r.run_rev)
      next_r.coasted = 1'b0;
    // run passes through with sequencing off unless drive_fault is high, else reaches the drive only in drive operation
    if (!seq_act)
    begin
      next_r.run_fwd = forward_run_command & ~reverse_run_command & ~drive_fault;
      next_r.run_rev = reverse_run_command & ~forward_run_command & ~drive_fault;
    end
    else if (bypass_enable_input && drive_select_input && r.mc_out && !fault_now
             && !thermal_bad && !r.auto_byp && (!r.coasted || sw_done)) // R6 R15
    begin
      next_r.run_fwd = forward_run_command & ~reverse_run_command;
      next_r.run_rev = reverse_run_command & ~forward_run_command;
    end
    else
    begin
      next_r.run_fwd = 1'b0;
      next_r.run_rev = 1'b0;
    end
    // output terminals follow the contactor flops in the same edge
    for (int i = 0; i < NTERM; i++)
    begin
      case (r.out_func[i])
        FC_IN_CONT: next_r.term[i] = next_r.mc_in; // R9
        FC_BYP_CONT: next_r.term[i] = next_r.mc_byp; // R9
        FC_OUT_CONT: next_r.term[i] = next_r.mc_out; // R9
        default: next_r.term[i] = 1'b0;
      endcase
    end
    // mode shown in status
    if (!seq_act)
      next_r.st = ST_PASS;
    else if (thermal_bad || fault_now)
      next_r.st = ST_FAULT;
    else if (next_r.mc_out)
      next_r.st = ST_DRIVE;
    else if (next_r.mc_byp)
      next_r.st = ST_BYPASS;
    else
      next_r.st = ST_OFF;
  end

  // ========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.interlock <= INTERLOCK_RST;
      r.start_wait <= START_WAIT_RST;
      r.cushion <= CUSHION_RST;
      r.auto_freq <= AUTO_FREQ_OFF;
      r.in_func <= IN_FUNC_RST;
      r.out_func <= OUT_FUNC_RST;
      r.st <= ST_OFF;
    end
    else
      r <= next_r;
  end

  // outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign input_contactor_ctrl = r.mc_in;
  assign bypass_contactor_ctrl = r.mc_byp;
  assign output_contactor_ctrl = r.mc_out;
  assign out_term = r.term;
  assign drive_run_fwd = r.run_fwd;
  assign drive_run_rev = r.run_rev;

  // ========================================================================
  // assertions
  no_overlap_a: assert property ( // R17
    @(posedge pclk) disable iff (!presetn)
    !(bypass_contactor_ctrl && output_contactor_ctrl))
    else $error("bypass and output contactors closed together");

  thermal_release_a: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    seq_act && thermal_bad |=> !input_contactor_ctrl && !bypass_contactor_ctrl
      && !output_contactor_ctrl)
    else $error("contactor still closed with abnormal motor");

  fault_release_a: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    seq_act && drive_fault |=> !input_contactor_ctrl && !output_contactor_ctrl)
    else $error("input or output contactor closed at fault");

  disable_bypass_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    seq_act && !bypass_enable_input && !thermal_bad && !fault_now && !status_init_input
      |=> !bypass_contactor_ctrl && input_contactor_ctrl)
    else $error("bypass closed or input open while disabled");

  disable_hold_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    seq_act && !bypass_enable_input && !thermal_bad && !fault_now
      && !output_contactor_ctrl |=> !output_contactor_ctrl)
    else $error("output contactor changed while disabled");

  init_release_a: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    seq_act && status_init_input ##1 seq_act |-> !bypass_contactor_ctrl)
    else $error("bypass contactor closed during init");

  interlock_wait_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    $rose(bypass_contactor_ctrl) || $rose(output_contactor_ctrl)
      |-> $past(il_done) && !$past(bypass_contactor_ctrl || output_contactor_ctrl))
    else $error("contactor closed before interlock time");

  run_gate_a: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    $past(seq_act) && drive_run_fwd
      |-> $past(bypass_enable_input && drive_select_input) && output_contactor_ctrl)
    else $error("run passed outside drive operation");

endmodule : bcs_sequencer

/* dv/bcs_contactor_model.sv */
// Purpose: model of the contactors and mode switch beyond the sequencer
// Assumes: a contact makes as soon as its coil rises and breaks only after a drop-out delay
// Notes: counts cycles in which mains and drive output both reach the motor

`timescale 1ns/1ps

// ==========================================================================
// contactor model
module bcs_contactor_model #(
  parameter int DROP_DLY = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // contactor coils
  input wire logic byp_ctl,
  input wire logic out_ctl,
  // mode and status
  output logic external_mode,
  output logic [15:0] overlap_cnt
);
  int byp_hold;
  int out_hold;
  // operator keeps the drive in external operation
  assign external_mode = 1'b1;
  // contacts stay made for a drop-out time after the coil falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byp_hold <= 0;
      out_hold <= 0;
      overlap_cnt <= 16'h0000;
    end
    else
    begin
      byp_hold <= byp_ctl ? DROP_DLY : (byp_hold > 0 ? byp_hold - 1 : 0);
      out_hold <= out_ctl ? DROP_DLY : (out_hold > 0 ? out_hold - 1 : 0);
      if ((byp_ctl || byp_hold > 0) && (out_ctl || out_hold > 0))
      begin
        overlap_cnt <= overlap_cnt + 16'h0001;
      end
    end
  end
endmodule : bcs_contactor_model

/* dv/test_bypass_contactor_sequencer.sv */
// Purpose: self-checking bench for the bypass contactor sequencer
// Assumes: tick shortened to 10 pclk cycles; one APB transfer at a time
// Notes: times are set in ticks so every wait is bounded in cycles

`timescale 1ns/1ps

// ==========================================================================
// bench top
module test_bypass_contactor_sequencer;
  import bcs_pkg::*;
  localparam int TK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic en, sel, fwd, rev, init, flt, ext_mode, in_c, byp_c, out_c, run_f, run_r;
  logic [FREQ_W-1:0] freq;
  logic [NTERM-1:0] in_term, out_term;
  logic [15:0] overlap_cnt;
  logic [3:0] ctl;
  logic [31:0] rst_tab [7] = '{32'h0000_0005, 32'h0000_000A, 32'h0000_0005,
    32'h0000_000A, 32'h0000_270F, 32'h0000_0000, 32'h0013_1211};
  int err_total, compares;
  // run, output, bypass and input contactor seen together
  assign ctl = {run_f, out_c, byp_c, in_c};

  // design and far side
  bcs_sequencer #(.TICK_CYCLES(TK)) u_bcs_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bypass_enable_input(en),
    .drive_select_input(sel), .forward_run_command(fwd), .reverse_run_command(rev),
    .status_init_input(init), .drive_fault(flt), .external_mode(ext_mode),
    .output_freq(freq), .in_term(in_term), .input_contactor_ctrl(in_c),
    .bypass_contactor_ctrl(byp_c), .output_contactor_ctrl(out_c), .out_term(out_term),
    .drive_run_fwd(run_f), .drive_run_rev(run_r));
  bcs_contactor_model u_bcs_contactor_model (.pclk(pclk), .presetn(presetn),
    .byp_ctl(byp_c), .out_ctl(out_c), .external_mode(ext_mode),
    .overlap_cnt(overlap_cnt));

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one APB transfer; waits up to 50 cycles for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // bounded wait for one bit of ctl, then compare it
  task wait_ctl(input int k, input logic v, input string nm);
    int n;
    n = 0;
    while (ctl[k] !== v && n < 600)
    begin
      @(posedge pclk);
      n++;
    end
    check(nm, ctl[k], v);
  endtask : wait_ctl

  task report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // watchdog
  initial
  begin
    #(20 * 30000);
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {en, sel, fwd, rev, init, flt, freq} = '0;
    in_term = 4'hF;
    presetn = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      check("reg reset", rd, rst_tab[i]);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", er, 1'b1);
    apb(1'b1, OFS_INTERLOCK, 32'h0000_0002);
    apb(1'b1, OFS_START_WAIT, 32'h0000_0001);
    apb(1'b1, OFS_CUSHION, 32'h0000_0005);
    apb(1'b1, OFS_IN_FUNC, 32'h0000_0007);
    apb(1'b0, OFS_IN_FUNC, 32'h0000_0000);
    check("in func", rd, 32'h0000_0007);
    $display("test registers done");
    cyc(40);
    check("disabled", ctl, 4'b0001);
    en <= 1'b1;
    wait_ctl(1, 1'b1, "bypass");
    check("bypass", ctl, 4'b0011);
    fwd <= 1'b1;
    sel <= 1'b1;
    cyc(5);
    check("interlock", ctl, 4'b0001);
    wait_ctl(2, 1'b1, "drive");
    check("start wait", ctl, 4'b0101);
    wait_ctl(3, 1'b1, "run");
    check("out term", out_term, 4'b0101);
    en <= 1'b0;
    cyc(3);
    check("hold out", ctl[2:0], 3'b101);
    en <= 1'b1;
    $display("test switching done");
    freq <= 16'hFFFF;
    cyc(30);
    check("auto off", ctl, 4'b1101);
    apb(1'b1, OFS_AUTO_FREQ, 32'h0000_1770);
    wait_ctl(1, 1'b1, "auto bypass");
    check("auto bypass", ctl[2:0], 3'b011);
    fwd <= 1'b0;
    apb(1'b1, OFS_AUTO_FREQ, 32'h0000_270F);
    wait_ctl(2, 1'b1, "auto back");
    $display("test auto done");
    in_term <= 4'hE;
    cyc(3);
    check("thermal", ctl, 4'b0000);
    in_term <= 4'hF;
    wait_ctl(2, 1'b1, "thermal end");
    flt <= 1'b1;
    cyc(3);
    check("fault", ctl, 4'b0000);
    flt <= 1'b0;
    cyc(3);
    check("latched", in_c, 1'b0);
    init <= 1'b1;
    cyc(3);
    check("init byp", byp_c, 1'b0);
    check("init hold", in_c, 1'b0);
    init <= 1'b0;
    wait_ctl(0, 1'b1, "init reclose");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    flt <= 1'b1;
    cyc(2);
    flt <= 1'b0;
    init <= 1'b1;
    cyc(30);
    check("no accept", in_c, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("fault kept", rd[5], 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("fault cleared", rd[5], 1'b0);
    init <= 1'b0;
    wait_ctl(0, 1'b1, "accept");
    flt <= 1'b1;
    wait_ctl(1, 1'b1, "byp at fault");
    check("at fault", ctl[2:0], 3'b010);
    init <= 1'b1;
    cyc(3);
    check("init open", byp_c, 1'b0);
    flt <= 1'b0;
    cyc(3);
    init <= 1'b0;
    sel <= 1'b0;
    wait_ctl(1, 1'b1, "bypass again");
    init <= 1'b1;
    cyc(3);
    check("init bypass", ctl[2:0], 3'b001);
    init <= 1'b0;
    sel <= 1'b1;
    rev <= 1'b1;
    wait_ctl(2, 1'b1, "rev drive");
    cyc(30);
    check("rev run", {run_r, run_f}, 2'b10);
    $display("test faults done");
    check("overlap", overlap_cnt, 16'h0000);
    report_and_stop();
  end
endmodule : test_bypass_contactor_sequencer
